// >>> src/hfps_pkg.sv
// hfps_pkg: constants and types for the hop frame power sequencer
// assumes a 100 MHz device clock; all counts derived from it here
package hfps_pkg;
  // clock rate in MHz
  localparam int CLK_MHZ = 100;
  // guard between hop edge and rx analog power, in ns
  localparam int GUARD_NS = 150;
  // guard rounds up to whole cycles (least time)
  localparam int GUARD_CYC_I = (GUARD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] GUARD_CYC = 16'(GUARD_CYC_I);
  // synth retune times at a 100 MHz device clock, in us
  localparam int RETUNE_FAST_US = 27;
  localparam int RETUNE_NORM_US = 185;
  localparam logic [15:0] RETUNE_FAST_CYC = 16'(RETUNE_FAST_US * CLK_MHZ);
  localparam logic [15:0] RETUNE_NORM_CYC = 16'(RETUNE_NORM_US * CLK_MHZ);
  // monitor receiver latencies, in us
  localparam int MON_ON_NB_US = 8;
  localparam int MON_ON_WB_US = 9;
  localparam int MON_OFF_NB_US = 6;
  localparam int MON_OFF_WB_US = 5;
  localparam logic [15:0] MON_ON_NB_CYC = 16'(MON_ON_NB_US * CLK_MHZ);
  localparam logic [15:0] MON_ON_WB_CYC = 16'(MON_ON_WB_US * CLK_MHZ);
  localparam logic [15:0] MON_OFF_NB_CYC = 16'(MON_OFF_NB_US * CLK_MHZ);
  localparam logic [15:0] MON_OFF_WB_CYC = 16'(MON_OFF_WB_US * CLK_MHZ);
  // tx frame countdown load and restore values
  localparam logic [3:0] TX_CD_LOAD = 4'h3;
  localparam logic [3:0] TX_CD_IDLE = 4'h4;
  // least tx power frame delay
  localparam logic [3:0] TX_FRAMES_MIN = 4'h1;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RX_DLY = 4'h1;
  localparam logic [3:0] REG_TX_DLY = 4'h2;
  localparam logic [3:0] REG_HOLD = 4'h3;
  localparam logic [3:0] REG_FRAMES = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  // control field positions
  localparam int CTRL_RETUNE = 0;
  localparam int CTRL_FAST = 1;
  localparam int CTRL_OSC_MUX = 2;
  localparam int CTRL_RX_ONLY = 3;
  localparam int CTRL_TX_ONLY = 4;
  localparam int CTRL_WIDEBAND = 5;
  // reset values
  localparam logic [15:0] RST_DLY = 16'h0000;
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [3:0] RST_FRAMES = 4'h1;
  // rx front end sequence states
  typedef enum logic [1:0] {HFPS_RX_OFF, HFPS_RX_WAIT, HFPS_RX_ON} hfps_rx_t;
  // tx front end sequence states
  typedef enum logic [1:0] {HFPS_TX_OFF, HFPS_TX_WAIT, HFPS_TX_ON} hfps_tx_t;
endpackage

// >>> src/hfps_sequencer.sv
// hfps_sequencer: frame level front end power sequencer for hopping
// assumes hop, setup and monitor inputs already synchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module hfps_sequencer (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_hop,
  input wire logic i_rx_setup,
  input wire logic i_tx_setup,
  input wire logic i_monitor_rx_en,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_rx_analog_on,
  output logic o_rx_interface_on,
  output logic o_tx_analog_on,
  output logic o_tx_interface_on,
  output logic o_monitor_rx_on
);
  import hfps_pkg::*;

  // larger of two cycle counts
  function automatic logic [15:0] max16(input logic [15:0] a,
                                        input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction

  // software registers
  logic [5:0] ctrl, next_ctrl; // mode bits
  logic [15:0] rx_analog_on_delay, next_rx_analog_on_delay;
  logic [15:0] tx_analog_on_delay, next_tx_analog_on_delay;
  logic [15:0] interface_hold_delay, next_interface_hold_delay;
  logic [3:0] tx_frames, next_tx_frames; // programmed frame delay
  logic [15:0] rdata, next_rdata;

  // input history for edge detection
  logic hop_q, next_hop_q;
  logic txs_q, next_txs_q;
  logic hop_edge, txs_rise, txs_fall;

  // sequence state
  hfps_rx_t rx_st, next_rx_st;
  hfps_tx_t tx_st, next_tx_st;
  logic [15:0] rx_cnt, next_rx_cnt; // rx power wait
  logic [15:0] tx_cnt, next_tx_cnt; // tx power wait
  logic [15:0] hold_cnt, next_hold_cnt; // rx interface hold
  logic [3:0] tx_power_frame_countdown, next_tx_power_frame_countdown;
  logic tx_seen_rise, next_tx_seen_rise; // setup rise since last hop
  logic tx_armed, next_tx_armed; // sequence running
  logic tx_extra, next_tx_extra; // extra frame pending (osc mux)
  logic tx_if, next_tx_if;
  logic rx_if, next_rx_if;
  logic [15:0] mon_cnt, next_mon_cnt;
  logic mon_on, next_mon_on;

  // derived timing
  logic [15:0] synth_retune_time;
  logic [15:0] rx_wait, tx_wait;
  logic [3:0] tx_frames_eff;
  logic [15:0] mon_on_lat, mon_off_lat;

  // edges of the sampled inputs
  always_comb begin
    hop_edge = i_hop & ~hop_q;
    txs_rise = i_tx_setup & ~txs_q;
    txs_fall = ~i_tx_setup & txs_q;
  end

  // delay selection
  always_comb begin
    // retune time at the 100 MHz clock, fast or normal
    synth_retune_time = ctrl[CTRL_FAST] ? RETUNE_FAST_CYC
                                        : RETUNE_NORM_CYC;
    // rx never sooner than the guard
    rx_wait = max16(rx_analog_on_delay, GUARD_CYC);
    // tx has no floor; rx is already off when tx starts
    tx_wait = tx_analog_on_delay;
    if (ctrl[CTRL_RETUNE]) begin
      rx_wait = max16(synth_retune_time, rx_wait);
      tx_wait = max16(synth_retune_time, tx_wait);
    end
    // frames above one only for tx only; zero reads as one
    if (!ctrl[CTRL_TX_ONLY] || tx_frames == 4'h0) begin
      tx_frames_eff = TX_FRAMES_MIN;
    end else begin
      tx_frames_eff = tx_frames;
    end
    mon_on_lat = ctrl[CTRL_WIDEBAND] ? MON_ON_WB_CYC : MON_ON_NB_CYC;
    mon_off_lat = ctrl[CTRL_WIDEBAND] ? MON_OFF_WB_CYC
                                      : MON_OFF_NB_CYC;
  end

  // register port: writes and one-cycle-late reads
  always_comb begin
    next_ctrl = ctrl;
    next_rx_analog_on_delay = rx_analog_on_delay;
    next_tx_analog_on_delay = tx_analog_on_delay;
    next_interface_hold_delay = interface_hold_delay;
    next_tx_frames = tx_frames;
    next_rdata = 16'h0000;
    if (i_wr) begin
      case (i_addr)
        REG_CTRL: next_ctrl = i_wdata[5:0];
        REG_RX_DLY: next_rx_analog_on_delay = i_wdata;
        REG_TX_DLY: next_tx_analog_on_delay = i_wdata;
        REG_HOLD: next_interface_hold_delay = i_wdata;
        REG_FRAMES: next_tx_frames = i_wdata[3:0];
        default: ; // unmapped writes ignored
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_CTRL: next_rdata = {10'h000, ctrl};
        REG_RX_DLY: next_rdata = rx_analog_on_delay;
        REG_TX_DLY: next_rdata = tx_analog_on_delay;
        REG_HOLD: next_rdata = interface_hold_delay;
        REG_FRAMES: next_rdata = {12'h000, tx_frames};
        // live state for software
        REG_STATUS: next_rdata = {7'h00, tx_power_frame_countdown,
                                  mon_on, rx_if, tx_if,
                                  o_tx_analog_on, o_rx_analog_on};
        default: next_rdata = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // register storage
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ctrl <= RST_CTRL;
      rx_analog_on_delay <= RST_DLY;
      tx_analog_on_delay <= RST_DLY;
      interface_hold_delay <= RST_DLY;
      tx_frames <= RST_FRAMES;
      rdata <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      rx_analog_on_delay <= next_rx_analog_on_delay;
      tx_analog_on_delay <= next_tx_analog_on_delay;
      interface_hold_delay <= next_interface_hold_delay;
      tx_frames <= next_tx_frames;
      rdata <= next_rdata;
    end
  end

  // sequencing next state
  always_comb begin
    next_hop_q = i_hop;
    next_txs_q = i_tx_setup;
    next_rx_st = rx_st;
    next_tx_st = tx_st;
    next_rx_cnt = rx_cnt;
    next_tx_cnt = tx_cnt;
    next_hold_cnt = hold_cnt;
    next_tx_power_frame_countdown = tx_power_frame_countdown;
    next_tx_seen_rise = tx_seen_rise | txs_rise;
    next_tx_armed = tx_armed;
    next_tx_extra = tx_extra;
    next_tx_if = tx_if;
    next_rx_if = rx_if;
    next_mon_cnt = mon_cnt;
    next_mon_on = mon_on;

    // interface start: falling edge in mux mode, rising edge otherwise
    if (ctrl[CTRL_OSC_MUX] ? txs_fall : txs_rise) begin
      next_tx_if = 1'b1;
    end

    // rx interface hold countdown after frame ends
    if (hold_cnt != 16'h0000) begin
      next_hold_cnt = hold_cnt - 16'h0001;
      if (hold_cnt == 16'h0001) begin
        next_rx_if = 1'b0;
      end
    end

    // wait counters toward analog power on
    case (rx_st)
      HFPS_RX_WAIT: begin
        if (rx_cnt <= 16'h0001) begin
          next_rx_st = HFPS_RX_ON;
        end else begin
          next_rx_cnt = rx_cnt - 16'h0001;
        end
      end
      default: ;
    endcase
    case (tx_st)
      HFPS_TX_WAIT: begin
        // rx must be off before tx starts
        if (tx_cnt == 16'h0000 && rx_st == HFPS_RX_OFF) begin
          next_tx_st = HFPS_TX_ON;
        end else if (tx_cnt != 16'h0000) begin
          next_tx_cnt = tx_cnt - 16'h0001;
        end
      end
      default: ;
    endcase

    // all frame level decisions happen on hop edges
    if (hop_edge) begin
      next_tx_seen_rise = txs_rise;
      // countdown: load on first high sample, then decrement
      if (!i_tx_setup && tx_power_frame_countdown == 4'h0) begin
        next_tx_power_frame_countdown = TX_CD_IDLE;
      end else if (i_tx_setup && tx_power_frame_countdown == TX_CD_IDLE) begin
        next_tx_power_frame_countdown = TX_CD_LOAD;
      end else if (tx_power_frame_countdown != 4'h0 &&
                   tx_power_frame_countdown != TX_CD_IDLE) begin
        next_tx_power_frame_countdown = tx_power_frame_countdown - 4'h1;
      end
      if (tx_st != HFPS_TX_OFF || tx_armed) begin
        // no setup rise during the last frame: tx goes down now
        if (!(tx_seen_rise | txs_rise)) begin
          next_tx_st = HFPS_TX_OFF;
          next_tx_armed = 1'b0;
          next_tx_if = 1'b0;
          next_tx_extra = 1'b0;
        end else if (tx_armed && tx_st == HFPS_TX_OFF) begin
          if (ctrl[CTRL_TX_ONLY] && tx_frames_eff != TX_FRAMES_MIN &&
              tx_power_frame_countdown > 4'h1) begin
            // still counting frames
          end else if (ctrl[CTRL_TX_ONLY] && ctrl[CTRL_OSC_MUX] &&
                       tx_frames_eff != TX_FRAMES_MIN && !tx_extra) begin
            next_tx_extra = 1'b1;
          end else begin
            next_tx_st = HFPS_TX_WAIT;
            next_tx_cnt = tx_wait;
          end
        end
      end else if (tx_seen_rise | txs_rise) begin
        // first setup rise seen during previous frame
        next_tx_armed = 1'b1;
      end
      // rx: always powered down on hop edge, rx frame follows rx setup
      next_rx_st = HFPS_RX_OFF;
      if (rx_if && !i_rx_setup) begin
        if (ctrl[CTRL_RX_ONLY] && interface_hold_delay != 16'h0000) begin
          next_hold_cnt = interface_hold_delay;
        end else begin
          next_rx_if = 1'b0;
        end
      end
      if (i_rx_setup && !(tx_armed | tx_seen_rise | txs_rise)) begin
        next_rx_st = HFPS_RX_WAIT;
        next_rx_cnt = rx_wait;
        next_rx_if = 1'b1;
        next_hold_cnt = 16'h0000;
      end
    end

    // monitor receiver follows host enable with latency
    if (mon_cnt != 16'h0000) begin
      next_mon_cnt = mon_cnt - 16'h0001;
      if (mon_cnt == 16'h0001) begin
        next_mon_on = i_monitor_rx_en;
      end
    end else if (i_monitor_rx_en != mon_on) begin
      next_mon_cnt = i_monitor_rx_en ? mon_on_lat : mon_off_lat;
    end
  end

  // sequencing state registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hop_q <= 1'b0;
      txs_q <= 1'b0;
      rx_st <= HFPS_RX_OFF;
      tx_st <= HFPS_TX_OFF;
      rx_cnt <= 16'h0000;
      tx_cnt <= 16'h0000;
      hold_cnt <= 16'h0000;
      tx_power_frame_countdown <= TX_CD_IDLE;
      tx_seen_rise <= 1'b0;
      tx_armed <= 1'b0;
      tx_extra <= 1'b0;
      tx_if <= 1'b0;
      rx_if <= 1'b0;
      mon_cnt <= 16'h0000;
      mon_on <= 1'b0;
    end else begin
      hop_q <= next_hop_q;
      txs_q <= next_txs_q;
      rx_st <= next_rx_st;
      tx_st <= next_tx_st;
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
      hold_cnt <= next_hold_cnt;
      tx_power_frame_countdown <= next_tx_power_frame_countdown;
      tx_seen_rise <= next_tx_seen_rise;
      tx_armed <= next_tx_armed;
      tx_extra <= next_tx_extra;
      tx_if <= next_tx_if;
      rx_if <= next_rx_if;
      mon_cnt <= next_mon_cnt;
      mon_on <= next_mon_on;
    end
  end

  // outputs from flops; analog enables decoded from the state flops
  assign o_rdata = rdata;
  assign o_rx_analog_on = (rx_st == HFPS_RX_ON);
  assign o_tx_analog_on = (tx_st == HFPS_TX_ON);
  assign o_rx_interface_on = rx_if;
  assign o_tx_interface_on = tx_if;
  assign o_monitor_rx_on = mon_on;
endmodule
`default_nettype wire

// >>> sim/hfps_sequencer_sva.sv
// hfps_sequencer_sva: port timing checks for the hop sequencer
// assumes one clock domain; bound onto every hfps_sequencer below
`timescale 1ns/1ps
`default_nettype none
module hfps_sequencer_sva (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_hop,
  input wire logic i_rx_setup,
  input wire logic i_tx_setup,
  input wire logic i_monitor_rx_en,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_rx_analog_on,
  input wire logic o_rx_interface_on,
  input wire logic o_tx_analog_on,
  input wire logic o_tx_interface_on,
  input wire logic o_monitor_rx_on
);
  import hfps_pkg::*;
  logic hop_q, tx_q, seen; // past levels, tx rise seen this frame
  logic next_hop_q, next_tx_q, next_seen;
  logic [15:0] since, en_hi; // cycles since hop, monitor request age
  logic [15:0] next_since, next_en_hi;
  logic hop_edge; // hop rose this cycle
  // next values; counts stop at full scale so they never wrap to small
  always_comb begin
    hop_edge = i_hop & ~hop_q;
    next_hop_q = i_hop;
    next_tx_q = i_tx_setup;
    next_seen = ~hop_edge & (seen | (i_tx_setup & ~tx_q));
    next_since = hop_edge ? 16'h0001 : since + {15'h0000, ~&since};
    next_en_hi = i_monitor_rx_en ? en_hi + {15'h0000, ~&en_hi} : 16'h0000;
  end
  // register stage; since starts full so no hop is pretended
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      {hop_q, tx_q, seen} <= 3'h0;
      since <= 16'hffff;
      en_hi <= 16'h0000;
    end else begin
      {hop_q, tx_q, seen} <= {next_hop_q, next_tx_q, next_seen};
      since <= next_since;
      en_hi <= next_en_hi;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_no_overlap; !(o_rx_analog_on && o_tx_analog_on); endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("rx and tx front ends on together");
  property p_rx_guard; $rose(o_rx_analog_on) |-> since >= GUARD_CYC; endproperty
  a_rx_guard: assert property (p_rx_guard)
    else $error("rx analog on inside guard");
  property p_tx_rx_off; $rose(o_tx_analog_on) |-> !o_rx_analog_on; endproperty
  a_tx_rx_off: assert property (p_tx_rx_off)
    else $error("tx powered while rx still on");
  property p_tx_drop;
    hop_edge && !seen && o_tx_analog_on |-> ##[1:3] !o_tx_analog_on;
  endproperty
  a_tx_drop: assert property (p_tx_drop)
    else $error("tx kept on without setup rise");
  property p_rx_fall; $fell(o_rx_analog_on) |-> since <= 16'h0003; endproperty
  a_rx_fall: assert property (p_rx_fall)
    else $error("rx analog dropped away from hop");
  property p_tx_fall; $fell(o_tx_analog_on) |-> since <= 16'h0003; endproperty
  a_tx_fall: assert property (p_tx_fall)
    else $error("tx analog dropped away from hop");
  property p_mon_on;
    $rose(o_monitor_rx_on) |-> en_hi > MON_ON_NB_CYC;
  endproperty
  a_mon_on: assert property (p_mon_on)
    else $error("monitor on too early");
  property p_mon_hold; en_hi == 16'h0398 |-> o_monitor_rx_on; endproperty
  a_mon_hold: assert property (p_mon_hold)
    else $error("monitor on too late");
  property p_unmapped;
    i_rd && i_addr > REG_STATUS |=> o_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule
bind hfps_sequencer hfps_sequencer_sva hfps_sequencer_sva_i (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_hop(i_hop),
  .i_rx_setup(i_rx_setup), .i_tx_setup(i_tx_setup),
  .i_monitor_rx_en(i_monitor_rx_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_rx_analog_on(o_rx_analog_on), .o_rx_interface_on(o_rx_interface_on),
  .o_tx_analog_on(o_tx_analog_on), .o_tx_interface_on(o_tx_interface_on),
  .o_monitor_rx_on(o_monitor_rx_on));
`default_nettype wire

// >>> sim/hfps_host_model.sv
// hfps_host_model: baseband side driving hop, setup and monitor lines
// assumes the bench gates each activity with a run level
`timescale 1ns/1ps
`default_nettype none
module hfps_host_model #(
  parameter int FRAME = 2000, // cycles per hop frame
  parameter int MON_START = 100, // hop to monitor request gap
  parameter int MON_STOP = 1300 // request drop, leaves off time plus guard
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_rx_run,
  input wire logic i_tx_run,
  input wire logic i_mon_run,
  input wire logic i_tx_on,
  output logic o_hop,
  output logic o_rx_setup,
  output logic o_tx_setup,
  output logic o_monitor_rx_en
);
  localparam int MID = FRAME / 2; // setup pulse far ahead of next hop
  int pos; // cycle inside the current frame
  // all lines change on the rising edge only
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pos <= 0;
      {o_hop, o_rx_setup, o_tx_setup, o_monitor_rx_en} <= 4'h0;
    end else begin
      pos <= (pos == FRAME - 1) ? 0 : pos + 1;
      o_hop <= (pos < 10); // short pulse, edge at frame start
      o_rx_setup <= i_rx_run;
      o_tx_setup <= i_tx_run && pos >= MID && pos < MID + 10;
      // request only inside a frame with tx on air
      o_monitor_rx_en <= i_mon_run && i_tx_on &&
        pos >= MON_START && pos < MON_STOP;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_hfps_sequencer.sv
// tb_hfps_sequencer: self checking bench for the hop frame sequencer
// assumes the host model drives the link and the bench the register bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(16'(g), 16'(e))
module tb_hfps_sequencer;
  import hfps_pkg::*;
  localparam int FRAME = 2000; // hop frame in cycles
  typedef struct packed {
    logic w; // write when set, else read and compare
    logic [3:0] a;
    logic [15:0] d; // write data or expected read data
  } hfps_row_t;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rx_run = 1'b0, tx_run = 1'b0, mon_run = 1'b0; // host activity
  logic i_hop, i_rx_setup, i_tx_setup, i_monitor_rx_en; // host lines
  logic [15:0] o_rdata;
  logic rx_an, rx_if, tx_an, tx_if, mon_on; // design outputs
  logic hop_q = 1'b0; // hop one cycle back
  int since = 0; // cycles since last hop edge
  int error_cnt = 0;
  int check_count = 0;
  logic [15:0] q; // read result
  // reset values, unmapped place, read back
  hfps_row_t rows [8] = '{{1'b0, REG_CTRL, 16'h0000},
    {1'b0, REG_RX_DLY, 16'h0000}, {1'b0, REG_FRAMES, 16'h0001},
    {1'b0, REG_STATUS, 16'h0080}, {1'b1, 4'hc, 16'hffff},
    {1'b0, 4'hc, 16'h0000}, {1'b1, REG_HOLD, 16'h0033},
    {1'b0, REG_HOLD, 16'h0033}};
  hfps_sequencer hfps_sequencer_i (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_hop(i_hop), .i_rx_setup(i_rx_setup),
    .i_tx_setup(i_tx_setup), .i_monitor_rx_en(i_monitor_rx_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_rx_analog_on(rx_an), .o_rx_interface_on(rx_if),
    .o_tx_analog_on(tx_an), .o_tx_interface_on(tx_if),
    .o_monitor_rx_on(mon_on));
  hfps_host_model #(.FRAME(FRAME)) hfps_host_model_i (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_rx_run(rx_run), .i_tx_run(tx_run),
    .i_mon_run(mon_run), .i_tx_on(tx_an), .o_hop(i_hop),
    .o_rx_setup(i_rx_setup), .o_tx_setup(i_tx_setup),
    .o_monitor_rx_en(i_monitor_rx_en));
  always #5 i_clk_sys = ~i_clk_sys;
  // own hop edge timer, same edge rule as the design
  always @(posedge i_clk_sys) begin
    hop_q <= i_hop;
    since <= (i_hop && !hop_q) ? 1 : since + 1;
  end
  task check(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one write cycle, then a quiet cycle so strobes never double up
  task bus_wr(input logic [3:0] a, input logic [15:0] d);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // data stand only in the cycle after the strobe
  task bus_rd(input logic [3:0] a, output logic [15:0] d);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk_sys);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return rx_an;
      1: return tx_an;
      2: return mon_on;
      3: return rx_if;
      default: return tx_if;
    endcase
  endfunction
  // bounded wait for a level, then check its place in the frame
  // levels are looked at 1 ns after the edge, once they have settled;
  // returns on a rising edge so the caller drives right after it
  task wait_lvl(input int k, input logic v, input int lo, input int hi);
    int n;
    #1;
    for (n = 0; n < 4 * FRAME && pick(k) !== v; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    if (n == 4 * FRAME) begin
      error_cnt++;
      report_and_stop();
    end else begin
      `CHK(since >= lo && since <= hi, 1'b1);
    end
    @(posedge i_clk_sys);
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        bus_wr(rows[i].a, rows[i].d);
      end else begin
        bus_rd(rows[i].a, q);
        `CHK(q, rows[i].d);
      end
    end
    rx_run <= 1'b1;
    wait_lvl(3, 1'b1, 1, 3);
    wait_lvl(0, 1'b1, 15, 18);
    bus_wr(REG_RX_DLY, 16'h0028);
    wait_lvl(0, 1'b0, 1, 3);
    wait_lvl(0, 1'b1, 40, 43);
    // rx only: interface outlives the frame by the hold count
    bus_wr(REG_CTRL, 16'h0008);
    rx_run <= 1'b0;
    wait_lvl(0, 1'b0, 1, 3);
    wait_lvl(3, 1'b0, 51, 53);
    bus_wr(REG_TX_DLY, 16'h0014);
    tx_run <= 1'b1;
    wait_lvl(4, 1'b1, 1000, 1003);
    wait_lvl(1, 1'b1, 20, 23);
    mon_run <= 1'b1;
    wait_lvl(2, 1'b1, 895, 905);
    wait_lvl(2, 1'b0, 1895, 1905);
    // wideband latencies in the next tx frame
    bus_wr(REG_CTRL, 16'h0028);
    wait_lvl(2, 1'b1, 995, 1005);
    wait_lvl(2, 1'b0, 1795, 1805);
    mon_run <= 1'b0;
    // second reset with tx on air drops every output
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1 `CHK({rx_an, rx_if, tx_an, tx_if, mon_on}, 5'h00);
    @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    wait_lvl(1, 1'b1, 0, 3);
    tx_run <= 1'b0;
    wait_lvl(1, 1'b0, 1, 3);
    wait_lvl(4, 1'b0, 1, 3);
    report_and_stop();
  end
endmodule
`default_nettype wire
